// >>> include/pin_mux_pkg.sv
// Constants, register map and state layout for the pin output source multiplexer.
package pin_mux_pkg;

	// ==========================================================
	// Bus widths and responses
	localparam int          AXI_ADDR_W = 8;
	localparam int          AXI_DATA_W = 32;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// ==========================================================
	// Register indices; the byte address is four times the index
	localparam logic [7:0] IDX_PIN0_LEVEL = 8'h10;
	localparam logic [7:0] IDX_PIN2_CTL   = 8'h12;
	localparam logic [7:0] IDX_PORT_CFG   = 8'h20;
	localparam logic [7:0] IDX_TX_MASK    = 8'h21;
	localparam logic [7:0] IDX_PIN_STATUS = 8'h22;
	localparam logic [AXI_ADDR_W-1:0] ADDR_PIN0_LEVEL = {IDX_PIN0_LEVEL[5:0], 2'h0};
	localparam logic [AXI_ADDR_W-1:0] ADDR_PIN2_CTL   = {IDX_PIN2_CTL[5:0], 2'h0};
	localparam logic [AXI_ADDR_W-1:0] ADDR_PORT_CFG   = {IDX_PORT_CFG[5:0], 2'h0};
	localparam logic [AXI_ADDR_W-1:0] ADDR_TX_MASK    = {IDX_TX_MASK[5:0], 2'h0};
	localparam logic [AXI_ADDR_W-1:0] ADDR_PIN_STATUS = {IDX_PIN_STATUS[5:0], 2'h0};

	// ==========================================================
	// Field positions of pin2_output_control, port configuration and pin status
	localparam int DRIVE_EN_BIT  = 0;
	localparam int SW_LEVEL_BIT  = 1;
	localparam int SRC_LSB       = 2;
	localparam int SEL_LSB       = 5;
	localparam int SW_MODE_BIT   = 4;
	localparam int STAT_LEVEL_BIT = 0;
	localparam int STAT_EN_BIT   = 1;

	// ==========================================================
	// Reset values
	localparam logic [7:0] PIN2_CTL_RESET = 8'h00;
	localparam logic [3:0] RX_ENABLE_RESET = 4'h0;
	localparam logic [7:0] TX_MASK_RESET  = 8'h00;

	// ==========================================================
	// Source codes
	localparam logic [2:0] SRC_DEV_STATUS = 3'h4;
	localparam logic [2:0] SRC_RESERVED   = 3'h5;

	// Selection codes
	localparam logic [2:0] SEL_0 = 3'h0;
	localparam logic [2:0] SEL_1 = 3'h1;
	localparam logic [2:0] SEL_2 = 3'h2;
	localparam logic [2:0] SEL_3 = 3'h3;
	localparam logic [2:0] SEL_4 = 3'h4;
	localparam logic [2:0] SEL_5 = 3'h5;
	localparam logic [2:0] SEL_6 = 3'h6;
	localparam logic [2:0] SEL_7 = 3'h7;

	// ==========================================================
	// Whole state of the top module
	typedef struct packed {
		logic [7:0]            pinCtl;
		logic                  pin0Level;
		logic [3:0]            rxEnable;
		logic                  softwareMode;
		logic [7:0]            txMask;
		logic                  awSeen;
		logic [AXI_ADDR_W-1:0] awAddr;
		logic                  wSeen;
		logic [AXI_DATA_W-1:0] wData;
		logic                  wStrb0;
		logic                  bValid;
		logic [1:0]            bResp;
		logic                  rValid;
		logic [AXI_DATA_W-1:0] rData;
		logic [1:0]            rResp;
		logic                  pinLevel;
		logic                  pinEnable;
	} mux_state_t;

endpackage : pin_mux_pkg

// >>> hdl/pin_signal_select.sv
// Combinational choice of the pin level from source and selection codes.
`timescale 1ns/1ps
module pin_signal_select (
	input  wire logic [2:0]  src,
	input  wire logic [2:0]  sel,
	input  wire logic        pin0Level,
	input  wire logic [3:0]  rxEnable,
	input  wire logic [7:0]  txMask,
	input  wire logic [15:0] rxRemoteGpio,
	input  wire logic [3:0]  rxLock,
	input  wire logic [3:0]  rxPass,
	input  wire logic [3:0]  rxFrameValid,
	input  wire logic [3:0]  rxLineValid,
	input  wire logic        frameSyncPulse,
	input  wire logic [1:0]  txFrameValid,
	input  wire logic [1:0]  txLineValid,
	input  wire logic [1:0]  txSynced,
	input  wire logic [1:0]  txInterrupt,
	output logic             level
);
	import pin_mux_pkg::*;

	logic [1:0] rxPort;
	logic       txPort;
	logic [3:0] txSel;

	assign rxPort = src[1:0];
	assign txPort = src[0];
	assign txSel  = txPort ? txMask[7:4] : txMask[3:0];

	// ==========================================================
	// Selection
	always_comb begin
		level = 1'b0;
		if (!src[2]) begin
			case (sel)
				SEL_0, SEL_1, SEL_2, SEL_3: level = rxRemoteGpio[{rxPort, sel[1:0]}];
				SEL_4: level = rxLock[rxPort];
				SEL_5: level = rxPass[rxPort];
				SEL_6: level = rxFrameValid[rxPort];
				SEL_7: level = rxLineValid[rxPort];
				default: level = 1'b0;
			endcase
		end else if (src == SRC_DEV_STATUS) begin
			case (sel)
				SEL_0: level = pin0Level;
				SEL_1: level = |(rxLock & rxEnable);
				SEL_2, SEL_3: level = &(rxPass | ~rxEnable);
				SEL_4: level = frameSyncPulse;
				default: level = 1'b0;
			endcase
		end else if (src[1]) begin
			case (sel)
				SEL_0: level = &(rxPass | ~txSel);
				SEL_1: level = |(rxPass & txSel);
				SEL_2: level = txFrameValid[txPort];
				SEL_3: level = txLineValid[txPort];
				SEL_4: level = txSynced[txPort];
				SEL_5: level = txInterrupt[txPort];
				default: level = 1'b0;
			endcase
		end
	end

endmodule : pin_signal_select

// >>> hdl/pin_output_source_mux.sv
// Output path of one general-purpose pin with its AXI4-Lite register slave.
`timescale 1ns/1ps
module pin_output_source_mux #(
	parameter int RX_PORTS = 4,
	parameter int TX_PORTS = 2
) (
	input  wire logic                              sys_clk,
	input  wire logic                              rst_n,
	input  wire logic [pin_mux_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                              s_axi_awvalid,
	output logic                                   s_axi_awready,
	input  wire logic [pin_mux_pkg::AXI_DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]                        s_axi_wstrb,
	input  wire logic                              s_axi_wvalid,
	output logic                                   s_axi_wready,
	output logic [1:0]                             s_axi_bresp,
	output logic                                   s_axi_bvalid,
	input  wire logic                              s_axi_bready,
	input  wire logic [pin_mux_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                              s_axi_arvalid,
	output logic                                   s_axi_arready,
	output logic [pin_mux_pkg::AXI_DATA_W-1:0]     s_axi_rdata,
	output logic [1:0]                             s_axi_rresp,
	output logic                                   s_axi_rvalid,
	input  wire logic                              s_axi_rready,
	input  wire logic [15:0]                       rxRemoteGpio,
	input  wire logic [3:0]                        rxLock,
	input  wire logic [3:0]                        rxPass,
	input  wire logic [3:0]                        rxFrameValid,
	input  wire logic [3:0]                        rxLineValid,
	input  wire logic                              frameSyncPulse,
	input  wire logic [1:0]                        txFrameValid,
	input  wire logic [1:0]                        txLineValid,
	input  wire logic [1:0]                        txSynced,
	input  wire logic [1:0]                        txInterrupt,
	output logic                                   pinOut,
	output logic                                   pinOe
);
	import pin_mux_pkg::*;

	// ==========================================================
	// Elaboration checks
	// The three-bit codes only name four receive and two transmit ports.
	if (RX_PORTS != 4 || TX_PORTS != 2) begin : g_bad_ports
		$error("Port counts other than four receive and two transmit are unsupported.");
	end

	mux_state_t st;
	mux_state_t next_st;
	logic       selLevel;
	logic       writeFire;
	logic [2:0] src;
	logic [2:0] sel;

	assign src = st.pinCtl[SRC_LSB +: 3];
	assign sel = st.pinCtl[SEL_LSB +: 3];

	pin_signal_select u_select (
		.src            (src),
		.sel            (sel),
		.pin0Level      (st.pin0Level),
		.rxEnable       (st.rxEnable),
		.txMask         (st.txMask),
		.rxRemoteGpio   (rxRemoteGpio),
		.rxLock         (rxLock),
		.rxPass         (rxPass),
		.rxFrameValid   (rxFrameValid),
		.rxLineValid    (rxLineValid),
		.frameSyncPulse (frameSyncPulse),
		.txFrameValid   (txFrameValid),
		.txLineValid    (txLineValid),
		.txSynced       (txSynced),
		.txInterrupt    (txInterrupt),
		.level          (selLevel)
	);

	// ==========================================================
	// Bus handshakes
	assign s_axi_awready = !st.awSeen && !st.bValid;
	assign s_axi_wready  = !st.wSeen && !st.bValid;
	assign s_axi_arready = !st.rValid;
	assign s_axi_bvalid  = st.bValid;
	assign s_axi_bresp   = st.bResp;
	assign s_axi_rvalid  = st.rValid;
	assign s_axi_rdata   = st.rData;
	assign s_axi_rresp   = st.rResp;
	assign writeFire     = st.awSeen && st.wSeen && !st.bValid;

	// ==========================================================
	// Next state
	always_comb begin
		next_st = st;
		if (s_axi_awvalid && s_axi_awready) begin
			next_st.awSeen = 1'b1;
			next_st.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_st.wSeen  = 1'b1;
			next_st.wData  = s_axi_wdata;
			next_st.wStrb0 = s_axi_wstrb[0];
		end
		if (st.bValid && s_axi_bready) begin
			next_st.bValid = 1'b0;
		end
		// Register fields all lie in the low eight bits, so only byte lane 0 can change them.
		if (writeFire) begin
			next_st.awSeen = 1'b0;
			next_st.wSeen  = 1'b0;
			next_st.bValid = 1'b1;
			next_st.bResp  = RESP_OKAY;
			case (st.awAddr)
				ADDR_PIN2_CTL: begin
					if (st.wStrb0) next_st.pinCtl = st.wData[7:0];
				end
				ADDR_PIN0_LEVEL: begin
					if (st.wStrb0) next_st.pin0Level = st.wData[SW_LEVEL_BIT];
				end
				ADDR_PORT_CFG: begin
					if (st.wStrb0) begin
						next_st.rxEnable     = st.wData[3:0];
						next_st.softwareMode = st.wData[SW_MODE_BIT];
					end
				end
				ADDR_TX_MASK: begin
					if (st.wStrb0) next_st.txMask = st.wData[7:0];
				end
				ADDR_PIN_STATUS: next_st.bResp = RESP_OKAY;
				default: next_st.bResp = RESP_SLVERR;
			endcase
		end
		if (st.rValid && s_axi_rready) begin
			next_st.rValid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_st.rValid = 1'b1;
			next_st.rResp  = RESP_OKAY;
			next_st.rData  = '0;
			case (s_axi_araddr)
				ADDR_PIN2_CTL:   next_st.rData[7:0] = st.pinCtl;
				ADDR_PIN0_LEVEL: next_st.rData[SW_LEVEL_BIT] = st.pin0Level;
				ADDR_PORT_CFG: begin
					next_st.rData[3:0]         = st.rxEnable;
					next_st.rData[SW_MODE_BIT] = st.softwareMode;
				end
				ADDR_TX_MASK:    next_st.rData[7:0] = st.txMask;
				ADDR_PIN_STATUS: begin
					next_st.rData[STAT_LEVEL_BIT] = st.pinLevel;
					next_st.rData[STAT_EN_BIT]    = st.pinEnable;
				end
				default: next_st.rResp = RESP_SLVERR;
			endcase
		end
		// registered pin level.
		// A flop after the mux hides decode hazards while the fields are rewritten.
		if (st.softwareMode) begin
			next_st.pinLevel = st.pinCtl[SW_LEVEL_BIT];
		end else begin
			next_st.pinLevel = selLevel;
		end
		next_st.pinEnable = st.pinCtl[DRIVE_EN_BIT];
	end

	// ==========================================================
	// State register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st              <= '0;
			st.pinCtl       <= PIN2_CTL_RESET;
			st.rxEnable     <= RX_ENABLE_RESET;
			st.txMask       <= TX_MASK_RESET;
			st.bResp        <= RESP_OKAY;
			st.rResp        <= RESP_OKAY;
		end else begin
			st <= next_st;
		end
	end

	assign pinOut = st.pinLevel;
	assign pinOe  = st.pinEnable;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	logic        ctlWrite;
	logic        muxMode;
	logic        txSrc;
	logic [3:0]  txGroup;
	logic [40:0] pinInputs;
	assign ctlWrite  = writeFire && st.awAddr == ADDR_PIN2_CTL && st.wStrb0;
	assign muxMode   = !st.softwareMode && !ctlWrite;
	assign txSrc     = muxMode && src[2:1] == 2'h3;
	assign txGroup   = src[0] ? st.txMask[7:4] : st.txMask[3:0];
	// Every pin-side input; a change in it may legally move the pin in a write cycle.
	assign pinInputs = {rxRemoteGpio, rxLock, rxPass, rxFrameValid, rxLineValid,
		frameSyncPulse, txFrameValid, txLineValid, txSynced, txInterrupt};

	drive_off_a: assert property (ctlWrite && !st.wData[DRIVE_EN_BIT] |-> ##2 !pinOe)
		else $error("Pin still driven after enable cleared.");
	drive_on_a: assert property (ctlWrite && st.wData[DRIVE_EN_BIT] |-> ##2 pinOe)
		else $error("Pin not driven after enable set.");
	drive_follow_a: assert property (pinOe == $past(st.pinCtl[DRIVE_EN_BIT]))
		else $error("Driver enable does not follow its bit.");
	sw_level_a: assert property (st.softwareMode && !ctlWrite
		|=> pinOut == $past(st.pinCtl[SW_LEVEL_BIT]))
		else $error("Software level not on pin.");

	// ==========================================================
	// Selection checks
	// remote GPIO forwarded.
	rx_gpio_a: assert property (muxMode && !src[2] && !sel[2]
		|=> pinOut == $past(rxRemoteGpio[{src[1:0], sel[1:0]}]))
		else $error("Remote GPIO not forwarded.");
	rx_lock_a: assert property (muxMode && !src[2] && sel == SEL_4
		|=> pinOut == $past(rxLock[src[1:0]]))
		else $error("Receive lock not forwarded.");
	rx_pass_a: assert property (muxMode && !src[2] && sel == SEL_5
		|=> pinOut == $past(rxPass[src[1:0]]))
		else $error("Receive pass not forwarded.");
	rx_frame_a: assert property (muxMode && !src[2] && sel == SEL_6
		|=> pinOut == $past(rxFrameValid[src[1:0]]))
		else $error("Receive frame valid not forwarded.");
	rx_line_a: assert property (muxMode && !src[2] && sel == SEL_7
		|=> pinOut == $past(rxLineValid[src[1:0]]))
		else $error("Receive line valid not forwarded.");
	status_pin0_a: assert property (muxMode && src == SRC_DEV_STATUS && sel == SEL_0
		|=> pinOut == $past(st.pin0Level))
		else $error("Pin 0 level not forwarded.");
	status_or_a: assert property (muxMode && src == SRC_DEV_STATUS && sel == SEL_1
		|=> pinOut == $past(|(rxLock & st.rxEnable)))
		else $error("Lock OR wrong.");
	status_and_a: assert property (muxMode && src == SRC_DEV_STATUS && sel[2:1] == 2'h1
		|=> pinOut == $past((rxPass & st.rxEnable) == st.rxEnable))
		else $error("Pass AND wrong.");
	frame_sync_a: assert property (muxMode && src == SRC_DEV_STATUS && sel == SEL_4
		|=> pinOut == $past(frameSyncPulse))
		else $error("Frame sync not forwarded.");
	status_rsvd_a: assert property (muxMode && src == SRC_DEV_STATUS && sel > SEL_4
		|=> !pinOut)
		else $error("Reserved status selection not low.");
	tx_and_a: assert property (txSrc && sel == SEL_0
		|=> pinOut == $past((rxPass & txGroup) == txGroup))
		else $error("Transmit pass AND wrong.");
	tx_or_a: assert property (txSrc && sel == SEL_1
		|=> pinOut == $past((rxPass & txGroup) != 4'h0))
		else $error("Transmit pass OR wrong.");
	tx_frame_a: assert property (txSrc && sel == SEL_2
		|=> pinOut == $past(txFrameValid[src[0]]))
		else $error("Transmit frame valid not forwarded.");
	tx_line_a: assert property (txSrc && sel == SEL_3
		|=> pinOut == $past(txLineValid[src[0]]))
		else $error("Transmit line valid not forwarded.");
	tx_sync_a: assert property (txSrc && sel == SEL_4
		|=> pinOut == $past(txSynced[src[0]]))
		else $error("Synchronized indication not forwarded.");
	tx_irq_a: assert property (txSrc && sel == SEL_5
		|=> pinOut == $past(txInterrupt[src[0]]))
		else $error("Transmit interrupt not forwarded.");
	reserved_low_a: assert property (muxMode && src == SRC_RESERVED |=> !pinOut)
		else $error("Reserved source not low.");
	tx_rsvd_a: assert property (txSrc && sel[2:1] == 2'h3 |=> !pinOut)
		else $error("Reserved transmit selection not low.");
	reset_zero_a: assert property ($rose(rst_n) |-> st.pinCtl == PIN2_CTL_RESET && !pinOe)
		else $error("Control not zero after reset.");
	pin_hold_a: assert property (ctlWrite && !st.softwareMode && $stable(pinInputs)
		|=> $stable(pinOut))
		else $error("Pin changed in the write cycle.");

	write_cov_c: cover property (ctlWrite ##[1:4] s_axi_bvalid && s_axi_bready);
	read_cov_c: cover property (s_axi_arvalid && s_axi_arready ##1 s_axi_rvalid);
	tx_src_cov_c: cover property (pinOe && src[2:1] == 2'h3 && pinOut);
	status_cov_c: cover property (pinOe && src == SRC_DEV_STATUS && pinOut);
	sw_cov_c: cover property (st.softwareMode && pinOe && pinOut);

endmodule : pin_output_source_mux

// >>> dv/pin_board_model.sv
// Board-side model that resolves and samples the general-purpose pin.
`timescale 1ns/1ps
module pin_board_model (
	input  wire logic sys_clk,
	input  wire logic pinOut,
	input  wire logic pinOe,
	output logic      padLevel
);
	// ==========================================================
	// Pad resolution
	logic padWire;
	// pull-up when undriven
	// The board pull-up makes a released pin read high, so a stale low level cannot pass.
	assign padWire = pinOe ? pinOut : 1'b1;
	always_ff @(posedge sys_clk) begin
		padLevel <= padWire;
	end
endmodule : pin_board_model

// >>> dv/pin_output_source_mux_tb_top.sv
// Self-checking testbench of the pin output source multiplexer.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
	$display("ERROR %0t: got %h want %h", $time, a, b); end end
module pin_output_source_mux_tb_top;
	import pin_mux_pkg::*;
	// ==========================================================
	// Signals
	logic        sys_clk, rst_n, padLevel, pinOut, pinOe;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [15:0] rxRemoteGpio;
	logic [3:0]  rxLock, rxPass, rxFrameValid, rxLineValid;
	logic [1:0]  txFrameValid, txLineValid, txSynced, txInterrupt;
	logic        frameSyncPulse;
	logic [31:0] rxv;
	logic [8:0]  txv;
	int          errors, checks;
	assign {rxLineValid, rxFrameValid, rxPass, rxLock, rxRemoteGpio} = rxv;
	assign {frameSyncPulse, txInterrupt, txSynced, txLineValid, txFrameValid} = txv;

	pin_output_source_mux uut (.sys_clk(sys_clk), .rst_n(rst_n),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rxRemoteGpio(rxRemoteGpio),
		.rxLock(rxLock), .rxPass(rxPass), .rxFrameValid(rxFrameValid), .rxLineValid(rxLineValid),
		.frameSyncPulse(frameSyncPulse), .txFrameValid(txFrameValid), .txLineValid(txLineValid),
		.txSynced(txSynced), .txInterrupt(txInterrupt), .pinOut(pinOut), .pinOe(pinOe));
	pin_board_model board (.sys_clk(sys_clk), .pinOut(pinOut), .pinOe(pinOe), .padLevel(padLevel));

	// ==========================================================
	// Bus tasks
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w, done;
		done = 1'b0;
		@(posedge sys_clk);
		s_axi_awaddr  <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata   <= d;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		while (!done) begin
			@(negedge sys_clk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			done = s_axi_bvalid && s_axi_bready;
			r = s_axi_bresp;
			@(posedge sys_clk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (done) s_axi_bready <= 1'b0;
		end
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar, done;
		done = 1'b0;
		@(posedge sys_clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		while (!done) begin
			@(negedge sys_clk);
			ar = s_axi_arvalid && s_axi_arready;
			done = s_axi_rvalid && s_axi_rready;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge sys_clk);
			if (ar) s_axi_arvalid <= 1'b0;
			if (done) s_axi_rready <= 1'b0;
		end
	endtask : axi_read

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [1:0] r;
		axi_write(a, {24'h0, d}, r);
	endtask : wr

	// ==========================================================
	// Pin helpers
	task automatic expect_pin(input logic lvl, input logic oe);
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		`CHK(pinOut, lvl)
		`CHK(pinOe, oe)
		`CHK(padLevel, oe ? lvl : 1'b1)
	endtask : expect_pin

	task automatic route(input int src, input int sel);
		wr(ADDR_PIN2_CTL, 8'((sel << SEL_LSB) | (src << SRC_LSB) | 1));
	endtask : route

	task automatic case_pin(input int src, input int sel, input logic [31:0] rv,
		input logic [8:0] tv, input logic lvl);
		route(src, sel);
		rxv <= rv;
		txv <= tv;
		expect_pin(lvl, 1'b1);
	endtask : case_pin

	function automatic int rx_bit(input int p, input int s);
		return (s < 4) ? 4 * p + s : 16 + 4 * (s - 4) + p;
	endfunction : rx_bit

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0]  r;
		axi_read(ADDR_PIN2_CTL, d, r);
		`CHK(d, {24'h0, PIN2_CTL_RESET})
		`CHK(r, RESP_OKAY)
		`CHK(pinOe, 1'b0)
		axi_read(8'hFC, d, r);
		`CHK(r, RESP_SLVERR)
		`CHK(d, 32'h0)
		axi_write(8'hFC, 32'hFF, r);
		`CHK(r, RESP_SLVERR)
		axi_write(ADDR_PIN2_CTL, {24'h0, PIN2_CTL_RESET}, r);
		`CHK(r, RESP_OKAY)
		$display("test reset done");
	endtask : t_reset

	task automatic t_software;
		logic [31:0] d;
		logic [1:0]  r;
		wr(ADDR_PORT_CFG, 8'h10);
		wr(ADDR_PIN2_CTL, 8'h03);
		expect_pin(1'b1, 1'b1);
		axi_read(ADDR_PIN_STATUS, d, r);
		`CHK(d, 32'h3)
		wr(ADDR_PIN2_CTL, 8'h01);
		expect_pin(1'b0, 1'b1);
		wr(ADDR_PIN2_CTL, 8'h02);
		expect_pin(1'b1, 1'b0);
		@(posedge sys_clk);
		s_axi_wstrb <= 4'hE;
		wr(ADDR_PIN2_CTL, 8'hFF);
		s_axi_wstrb <= 4'hF;
		axi_read(ADDR_PIN2_CTL, d, r);
		`CHK(d, 32'h2)
		wr(ADDR_PORT_CFG, 8'h00);
		$display("test software done");
	endtask : t_software

	task automatic t_rx;
		route(0, 0);
		rxv <= 32'h0;
		expect_pin(1'b0, 1'b1);
		@(posedge sys_clk);
		rxv <= 32'h1;
		@(negedge sys_clk);
		`CHK(pinOut, 1'b0)
		@(negedge sys_clk);
		`CHK(pinOut, 1'b1)
		for (int p = 0; p < 4; p++) begin
			for (int s = 0; s < 8; s++) begin
				case_pin(p, s, 32'h1 << rx_bit(p, s), 9'h1FF, 1'b1);
				case_pin(p, s, ~(32'h1 << rx_bit(p, s)), 9'h0, 1'b0);
			end
		end
		$display("test receive done");
	endtask : t_rx

	task automatic t_status;
		wr(ADDR_PORT_CFG, 8'h05);
		wr(ADDR_PIN0_LEVEL, 8'h02);
		case_pin(4, 0, 32'h0, 9'h0, 1'b1);
		wr(ADDR_PIN0_LEVEL, 8'h00);
		case_pin(4, 0, '1, 9'h1FF, 1'b0);
		case_pin(4, 1, 32'hA << 16, 9'h0, 1'b0);
		case_pin(4, 1, 32'h4 << 16, 9'h0, 1'b1);
		for (int s = 2; s < 4; s++) begin
			case_pin(4, s, 32'h5 << 20, 9'h0, 1'b1);
			case_pin(4, s, 32'hE << 20, 9'h1FF, 1'b0);
		end
		case_pin(4, 4, 32'h0, 9'h100, 1'b1);
		case_pin(4, 4, '1, 9'h0FF, 1'b0);
		for (int s = 5; s < 8; s++) begin
			case_pin(4, s, '1, 9'h1FF, 1'b0);
			case_pin(5, s - 5, '1, 9'h1FF, 1'b0);
		end
		$display("test status done");
	endtask : t_status

	task automatic t_tx;
		wr(ADDR_TX_MASK, 8'h3C);
		case_pin(6, 0, 32'hC << 20, 9'h0, 1'b1);
		case_pin(6, 0, 32'h7 << 20, 9'h0, 1'b0);
		case_pin(6, 1, 32'h4 << 20, 9'h0, 1'b1);
		case_pin(6, 1, 32'h3 << 20, 9'h0, 1'b0);
		case_pin(7, 0, 32'h3 << 20, 9'h0, 1'b1);
		case_pin(7, 0, 32'hD << 20, 9'h0, 1'b0);
		case_pin(7, 1, 32'hC << 20, 9'h0, 1'b0);
		case_pin(7, 1, 32'h2 << 20, 9'h0, 1'b1);
		for (int t = 0; t < 2; t++) begin
			for (int s = 2; s < 6; s++) begin
				case_pin(6 + t, s, 32'h0, 9'h1 << (2 * (s - 2) + t), 1'b1);
				case_pin(6 + t, s, '1, ~(9'h1 << (2 * (s - 2) + t)), 1'b0);
			end
			case_pin(6 + t, 6, '1, 9'h1FF, 1'b0);
			case_pin(6 + t, 7, '1, 9'h1FF, 1'b0);
		end
		$display("test transmit done");
	endtask : t_tx

	task automatic t_midreset;
		logic [31:0] d;
		logic [1:0]  r;
		route(7, 2);
		@(negedge sys_clk);
		`CHK(pinOe, 1'b1)
		@(posedge sys_clk);
		rst_n <= 1'b0;
		rxv   <= 32'h0;
		@(negedge sys_clk);
		`CHK(pinOe, 1'b0)
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		axi_read(ADDR_PIN2_CTL, d, r);
		`CHK(d, {24'h0, PIN2_CTL_RESET})
		expect_pin(1'b0, 1'b0);
		$display("test midreset done");
	endtask : t_midreset

	// ==========================================================
	// Run control
	task automatic finish_test;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : finish_test

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// The whole sequence needs under a thousand cycles; this leaves ample margin.
	initial begin
		#3_000_000;
		errors++;
		finish_test();
	end

	initial begin
		errors = 0;
		checks = 0;
		rst_n = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		rxv = 32'h0;
		txv = 9'h0;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset();
		t_software();
		t_rx();
		t_status();
		t_tx();
		t_midreset();
		finish_test();
	end
endmodule : pin_output_source_mux_tb_top
